// file: rtl/hbt_break_unit.sv
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "hbt_consts.svh"

// How it works
// - at most sixteen events; larger set refused
// - OR condition breaks on any enabled event
// - other group off at reset; one mode
// - cumulative AND remembers events until all seen
// - simultaneous AND needs all events together
// - subroutine: chosen event inside address range
// - six forward steps, reset point restarts
// - three states, nine paths, reset point
// - eight exception sources, each enabled separately
// - groups independent; any satisfied group breaks
// - optional delay of 0..65535 bus cycles
// - settings act only after apply command
// - OR re-enable clears the mask on overflow, else keeps it
module hbt_break_unit import hbt_pkg::*; #(
  parameter int ADDR_W = 32,
  parameter int DLY_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busCycle,
  input wire logic [15:0] evtHit,
  input wire logic [ADDR_W-1:0] pcAddr,
  input wire logic [7:0] excEvt,
  output logic breakReq
);
  // ========================================================================
  // elaboration checks
  if (ADDR_W < 1 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must be 1..32");
  end
  if (DLY_W != 16) begin : g_chk_dly
    $error("DLY_W must be 16 for the 0..65535 delay range");
  end

  // ========================================================================
  // declarations
  logic awHeld, wHeld, wrDo, arDo;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ, wMerged;
  logic [32:0] wrLook, rdLook;
  logic [3:0] wStrbQ;
  // staged settings, written by software
  logic sOrEn, sOthEn, sDlyEn;
  hbt_mode_t sMode;
  logic [15:0] sOrMask, sOthMask;
  logic [7:0] sExcMask;
  logic [DLY_W-1:0] sDelay;
  logic [ADDR_W-1:0] sLo, sHi;
  logic [23:0] sSeqEvt;
  logic [2:0] sSeqLen;
  logic [4:0] sRst;
  logic [8:0] sPath [`HBT_NUM_PATHS];
  // applied settings, used by the break logic
  logic aOrEn, aOthEn, aDlyEn;
  hbt_mode_t aMode;
  logic [15:0] aOrMask, aOthMask;
  logic [7:0] aExcMask;
  logic [DLY_W-1:0] aDelay;
  logic [ADDR_W-1:0] aLo, aHi;
  logic [23:0] aSeqEvt;
  logic [2:0] aSeqLen;
  logic [4:0] aRst;
  logic [8:0] aPath [`HBT_NUM_PATHS];
  // run state
  logic [15:0] cumSeen, hit;
  logic [2:0] seqStep;
  hbt_tstate_t tState;
  logic [1:0] tIdx;
  logic cfgErr, applyCmd, applyOk, clrCmd;
  logic [`HBT_EVT_CNT_W-1:0] evtTotal, othCnt;
  logic orMatch, othMatch, excMatch, anyMatch, rstHit;
  logic cumMatch, simMatch, subMatch, seqMatch, trnMatch;
  logic seqAdv, trnFire, stop, dlyBusy;
  logic [1:0] trnDest;
  logic [`HBT_NUM_PATHS-1:0] pFire;
  logic [1:0] pDest [`HBT_NUM_PATHS];

  // ========================================================================
  // helpers
  function automatic logic [`HBT_EVT_CNT_W-1:0] popCnt(input logic [15:0] v);
    logic [`HBT_EVT_CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < 16; i++) begin
      n = n + `HBT_EVT_CNT_W'(v[i]);
    end
    return n;
  endfunction

  // register read-back; bit 32 flags a mapped address
  function automatic logic [32:0] regRead(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h00000000};
    unique case (a)
      `HBT_OFF_CTRL: r[23:0] = {15'h0000, sDlyEn, 1'b0, sMode, 2'h0,
                               sOthEn, sOrEn};
      `HBT_OFF_CMD: r[0] = 1'b0;
      `HBT_OFF_ORMASK: r[15:0] = sOrMask;
      `HBT_OFF_OTHMASK: r[15:0] = sOthMask;
      `HBT_OFF_EXCMASK: r[7:0] = sExcMask;
      `HBT_OFF_DELAY: r[DLY_W-1:0] = sDelay;
      `HBT_OFF_RLO: r[ADDR_W-1:0] = sLo;
      `HBT_OFF_RHI: r[ADDR_W-1:0] = sHi;
      `HBT_OFF_SEQEVT: r[23:0] = sSeqEvt;
      `HBT_OFF_SEQLEN: r[2:0] = sSeqLen;
      `HBT_OFF_RSTPT: r[4:0] = sRst;
      `HBT_OFF_STATUS: r[9:0] = {2'(tIdx), 1'b0, seqStep, 1'b0,
                                 cfgErr, dlyBusy, breakReq};
      `HBT_OFF_CUMSEEN: r[15:0] = cumSeen;
      default: begin
        r = '0;
        for (int p = 0; p < `HBT_NUM_PATHS; p++) begin
          if (a == 8'(`HBT_OFF_PATH0 + 4 * p)) begin
            r = {1'b1, 23'h000000, sPath[p]};
          end
        end
      end
    endcase
    return r;
  endfunction

  // ========================================================================
  // AXI4-Lite write channel: address and data in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign wrDo = awHeld && wHeld && !s_axi_bvalid;
  always_comb begin
    wrLook = regRead(awAddrQ);
    rdLook = regRead({s_axi_araddr[7:2], 2'h0});
    for (int b = 0; b < 4; b++) begin
      wMerged[8*b +: 8] = wStrbQ[b] ? wDataQ[8*b +: 8] : wrLook[8*b +: 8];
    end
  end

  // hold address and data until both are present, then answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HBT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrQ <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (wrDo) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrLook[32] ? `HBT_RESP_OKAY : `HBT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel: one cycle to the data
  assign s_axi_arready = !s_axi_rvalid;
  assign arDo = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `HBT_RESP_OKAY;
    end else if (arDo) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdLook[31:0];
      s_axi_rresp <= rdLook[32] ? `HBT_RESP_OKAY : `HBT_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ========================================================================
  // staged settings
  assign othCnt = sOthEn ? popCnt(sOthMask) : '0;
  assign evtTotal = (sOrEn ? popCnt(sOrMask) : '0) + othCnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sOrEn <= 1'b1;
      sOthEn <= 1'b0;
      sMode <= HBT_CUM;
      sDlyEn <= 1'b0;
      sOrMask <= 16'h0000;
      sOthMask <= 16'h0000;
      sExcMask <= 8'h00;
      sDelay <= `HBT_DELAY_RST;
      sLo <= '0;
      sHi <= '0;
      sSeqEvt <= 24'h000000;
      sSeqLen <= 3'h1;
      sRst <= 5'h00;
      for (int p = 0; p < `HBT_NUM_PATHS; p++) begin
        sPath[p] <= 9'h000;
      end
    end else if (wrDo) begin
      unique case (awAddrQ)
        `HBT_OFF_CTRL: begin
          sOrEn <= wMerged[`HBT_CTRL_OREN];
          sOthEn <= wMerged[`HBT_CTRL_OTHEN];
          sMode <= hbt_mode_t'(wMerged[`HBT_CTRL_MODE +: 3]);
          sDlyEn <= wMerged[`HBT_CTRL_DLYEN];
          if (wMerged[`HBT_CTRL_OREN] && !sOrEn &&
              popCnt(sOrMask) + othCnt > `HBT_EVT_CNT_W'(`HBT_MAX_EVENTS)) begin
            sOrMask <= 16'h0000;
          end
        end
        `HBT_OFF_ORMASK: sOrMask <= wMerged[15:0];
        `HBT_OFF_OTHMASK: sOthMask <= wMerged[15:0];
        `HBT_OFF_EXCMASK: sExcMask <= wMerged[7:0];
        `HBT_OFF_DELAY: sDelay <= wMerged[DLY_W-1:0];
        `HBT_OFF_RLO: sLo <= wMerged[ADDR_W-1:0];
        `HBT_OFF_RHI: sHi <= wMerged[ADDR_W-1:0];
        `HBT_OFF_SEQEVT: sSeqEvt <= wMerged[23:0];
        `HBT_OFF_SEQLEN: sSeqLen <= wMerged[2:0];
        `HBT_OFF_RSTPT: sRst <= wMerged[4:0];
        default: begin
          for (int p = 0; p < `HBT_NUM_PATHS; p++) begin
            if (awAddrQ == 8'(`HBT_OFF_PATH0 + 4 * p)) begin
              sPath[p] <= wMerged[8:0];
            end
          end
        end
      endcase
    end
  end

  // ========================================================================
  // apply command
  assign applyCmd = wrDo && awAddrQ == `HBT_OFF_CMD && wMerged[`HBT_CMD_APPLY];
  assign clrCmd = wrDo && awAddrQ == `HBT_OFF_CMD && wMerged[`HBT_CMD_CLRBRK];
  assign applyOk = applyCmd
    && evtTotal <= `HBT_EVT_CNT_W'(`HBT_MAX_EVENTS)
    && sSeqLen != 3'h0 && sSeqLen <= 3'(`HBT_SEQ_STEPS)
    && sMode <= HBT_TRN;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aOrEn <= 1'b1;
      aOthEn <= 1'b0;
      aMode <= HBT_CUM;
      aDlyEn <= 1'b0;
      aOrMask <= 16'h0000;
      aOthMask <= 16'h0000;
      aExcMask <= 8'h00;
      aDelay <= `HBT_DELAY_RST;
      aLo <= '0;
      aHi <= '0;
      aSeqEvt <= 24'h000000;
      aSeqLen <= 3'h1;
      aRst <= 5'h00;
      for (int p = 0; p < `HBT_NUM_PATHS; p++) begin
        aPath[p] <= 9'h000;
      end
    end else if (applyOk) begin
      aOrEn <= sOrEn;
      aOthEn <= sOthEn;
      aMode <= sMode;
      aDlyEn <= sDlyEn;
      aOrMask <= sOrMask;
      aOthMask <= sOthMask;
      aExcMask <= sExcMask;
      aDelay <= sDelay;
      aLo <= sLo;
      aHi <= sHi;
      aSeqEvt <= sSeqEvt;
      aSeqLen <= sSeqLen;
      aRst <= sRst;
      aPath <= sPath;
    end
  end

  // result of the last apply
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgErr <= 1'b0;
    end else if (applyCmd) begin
      cfgErr <= !applyOk;
    end
  end

  // ========================================================================
  // match logic
  // sample per cycle
  assign hit = busCycle ? evtHit : 16'h0000;
  assign rstHit = aRst[`HBT_RST_EN] && hit[aRst[3:0]];
  assign orMatch = aOrEn && |(hit & aOrMask);
  assign excMatch = busCycle && |(excEvt & aExcMask);
  assign cumMatch = aOthMask != 16'h0000 && busCycle
    && ((cumSeen | hit) & aOthMask) == aOthMask;
  assign simMatch = aOthMask != 16'h0000 && (hit & aOthMask) == aOthMask;
  assign subMatch = |(hit & aOthMask) && pcAddr >= aLo && pcAddr <= aHi;
  assign seqAdv = hit[aSeqEvt[4 * seqStep +: 4]] && !rstHit;
  assign seqMatch = seqAdv && seqStep == aSeqLen - 3'h1;
  assign trnMatch = trnFire && trnDest == `HBT_PATH_TO_BRK && !rstHit;

  always_comb begin
    othMatch = 1'b0;
    if (aOthEn) begin
      unique case (aMode)
        HBT_CUM: othMatch = cumMatch;
        HBT_SIM: othMatch = simMatch;
        HBT_SUB: othMatch = subMatch;
        HBT_SEQ: othMatch = seqMatch;
        HBT_TRN: othMatch = trnMatch;
        default: othMatch = 1'b0;
      endcase
    end
  end

  assign anyMatch = orMatch || othMatch || excMatch;

  // ========================================================================
  // cumulative and sequential state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cumSeen <= 16'h0000;
    end else if (applyOk || (aMode == HBT_CUM && cumMatch)) begin
      cumSeen <= 16'h0000;
    end else if (aOthEn && aMode == HBT_CUM) begin
      cumSeen <= cumSeen | (hit & aOthMask);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seqStep <= 3'h0;
    end else if (applyOk || rstHit || seqMatch) begin
      seqStep <= 3'h0;
    end else if (aOthEn && aMode == HBT_SEQ && seqAdv) begin
      seqStep <= seqStep + 3'h1;
    end
  end

  // ========================================================================
  // transition machine
  always_comb begin
    unique case (tState)
      HBT_ST0: tIdx = 2'h0;
      HBT_ST1: tIdx = 2'h1;
      HBT_ST2: tIdx = 2'h2;
      default: tIdx = 2'h0;
    endcase
  end

  for (genvar p = 0; p < `HBT_NUM_PATHS; p++) begin : g_path
    hbt_trans_path u_path (
      .cfg(aPath[p]),
      .curIdx(tIdx),
      .hit(hit),
      .fire(pFire[p]),
      .dest(pDest[p])
    );
  end

  // lowest numbered firing path wins
  always_comb begin
    trnFire = 1'b0;
    trnDest = 2'h0;
    for (int p = `HBT_NUM_PATHS - 1; p >= 0; p--) begin
      if (pFire[p]) begin
        trnFire = 1'b1;
        trnDest = pDest[p];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tState <= HBT_ST0;
    end else if (applyOk || rstHit || trnMatch) begin
      tState <= HBT_ST0;
    end else if (aOthEn && aMode == HBT_TRN && trnFire) begin
      unique case (trnDest)
        2'h1: tState <= HBT_ST1;
        2'h2: tState <= HBT_ST2;
        default: tState <= HBT_ST0;
      endcase
    end
  end

  // ========================================================================
  // delay and break output
  // delay count
  hbt_delay_ctr #(.DLY_W(DLY_W)) u_delay (
    .clk(clk),
    .nrst(nrst),
    .tick(busCycle),
    .start(anyMatch),
    .enable(aDlyEn),
    .count(aDelay),
    .stop(stop),
    .busy(dlyBusy)
  );

  // stop request holds until software clears it; a new stop wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      breakReq <= 1'b0;
    end else if (stop) begin
      breakReq <= 1'b1;
    end else if (clrCmd) begin
      breakReq <= 1'b0;
    end
  end
endmodule

// file: rtl/hbt_consts.svh
`ifndef HBT_CONSTS_SVH
`define HBT_CONSTS_SVH

// ==========================================================================
// sizes of the break logic
`define HBT_MAX_EVENTS 16
`define HBT_SEQ_STEPS 6
`define HBT_NUM_PATHS 9
`define HBT_NUM_EXC 8
`define HBT_DELAY_RST 16'h0000
`define HBT_EVT_CNT_W 6

// ==========================================================================
// timing: least round trip between transition states (far side keeps it)
`define HBT_CLK_MHZ 20
`define HBT_RT_MIN_US 10
`define HBT_RT_MIN_CYC (`HBT_RT_MIN_US * `HBT_CLK_MHZ)

// ==========================================================================
// register byte offsets
`define HBT_OFF_CTRL 8'h00
`define HBT_OFF_CMD 8'h04
`define HBT_OFF_ORMASK 8'h08
`define HBT_OFF_OTHMASK 8'h0c
`define HBT_OFF_EXCMASK 8'h10
`define HBT_OFF_DELAY 8'h14
`define HBT_OFF_RLO 8'h18
`define HBT_OFF_RHI 8'h1c
`define HBT_OFF_SEQEVT 8'h20
`define HBT_OFF_SEQLEN 8'h24
`define HBT_OFF_RSTPT 8'h28
`define HBT_OFF_STATUS 8'h2c
`define HBT_OFF_PATH0 8'h30
`define HBT_OFF_CUMSEEN 8'h54

// ==========================================================================
// field positions and reset values
`define HBT_CTRL_RST 32'h00000001
`define HBT_CTRL_OREN 0
`define HBT_CTRL_OTHEN 1
`define HBT_CTRL_MODE 4
`define HBT_CTRL_DLYEN 8
`define HBT_CMD_APPLY 0
`define HBT_CMD_CLRBRK 1
`define HBT_ST_BRK 0
`define HBT_ST_BUSY 1
`define HBT_ST_CFGERR 2
`define HBT_ST_STEP 4
`define HBT_ST_TSTATE 8
`define HBT_PATH_FROM 0
`define HBT_PATH_TO 2
`define HBT_PATH_EVT 4
`define HBT_PATH_EN 8
`define HBT_PATH_TO_BRK 2'h3
`define HBT_RST_EN 4
`define HBT_RESP_OKAY 2'h0
`define HBT_RESP_SLVERR 2'h2

`endif

// file: rtl/hbt_pkg.sv
package hbt_pkg;
  // ========================================================================
  // combination modes of the other-conditions group
  typedef enum logic [2:0] {
    HBT_CUM = 3'h0,
    HBT_SIM = 3'h1,
    HBT_SUB = 3'h2,
    HBT_SEQ = 3'h3,
    HBT_TRN = 3'h4
  } hbt_mode_t;

  // ========================================================================
  // transition machine states, gray along the usual path
  typedef enum logic [1:0] {
    HBT_ST0 = 2'h0,
    HBT_ST1 = 2'h1,
    HBT_ST2 = 2'h3
  } hbt_tstate_t;
endpackage

// file: rtl/hbt_trans_path.sv
`timescale 1ns/1ps
`include "hbt_consts.svh"

// one event-triggered path of the transition machine
module hbt_trans_path import hbt_pkg::*; (
  input wire logic [8:0] cfg,
  input wire logic [1:0] curIdx,
  input wire logic [15:0] hit,
  output logic fire,
  output logic [1:0] dest
);
  // path fires when enabled, leaving the current state, on its event
  assign fire = cfg[`HBT_PATH_EN]
    && (cfg[`HBT_PATH_FROM +: 2] == curIdx)
    && hit[cfg[`HBT_PATH_EVT +: 4]];
  assign dest = cfg[`HBT_PATH_TO +: 2];
endmodule

// file: rtl/hbt_delay_ctr.sv
`timescale 1ns/1ps
`include "hbt_consts.svh"

// counts bus cycles between a breakpoint match and the stop
module hbt_delay_ctr import hbt_pkg::*; #(
  parameter int DLY_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic start,
  input wire logic enable,
  input wire logic [DLY_W-1:0] count,
  output logic stop,
  output logic busy
);
  logic [DLY_W-1:0] remain;

  // stop now when no delay, else on the last counted bus cycle
  always_comb begin
    if (!busy) begin
      stop = start && (!enable || count == '0);
    end else begin
      stop = tick && remain == DLY_W'(1);
    end
  end

  // load on match, count down once per bus cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      remain <= '0;
    end else if (!busy) begin
      if (start && enable && count != '0) begin
        busy <= 1'b1;
        remain <= count;
      end
    end else if (tick) begin
      remain <= remain - DLY_W'(1);
      if (remain == DLY_W'(1)) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: verif/hbt_break_unit_monitor.sv
`timescale 1ns/1ps

// ==========================================================================
// port checker for the break unit
module hbt_break_unit_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busCycle,
  input wire logic breakReq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // bus answers, holds and refusals
  a_write_answer: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("late write answer");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  a_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_data_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  // stop request only after a bus cycle, and held until cleared
  a_break_cause: assert property (
    $rose(breakReq) |-> $past(busCycle)) else $error("stop without cycle");
  a_break_sticky: assert property (
    $fell(breakReq) |-> s_axi_bvalid) else $error("stop fell alone");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_break: cover property ($rose(breakReq));
endmodule

// file: verif/hbt_bus_model.sv
`timescale 1ns/1ps

// ==========================================================================
// monitored target bus: cycles and detector outputs
module hbt_bus_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [15:0] evtReq,
  input wire logic [7:0] excReq,
  input wire logic [31:0] pcReq,
  output logic busCycle,
  output logic [15:0] evtHit,
  output logic [7:0] excEvt,
  output logic [31:0] pcAddr
);
  logic phase;
  logic live;

  // slow bus gives a cycle every other clock
  assign live = !slow || phase;

  // one sample per cycle
  // off-cycle detector lines carry junk that flips every clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 1'b0;
      busCycle <= 1'b0;
      evtHit <= 16'h0000;
      excEvt <= 8'h00;
    end else begin
      phase <= ~phase;
      busCycle <= live;
      evtHit <= live ? evtReq : ~evtHit;
      excEvt <= live ? excReq : ~excEvt;
    end
  end

  // slow round trips
  // program address moves only as the bench steps it, never in bursts
  assign pcAddr = pcReq;
endmodule

// file: verif/hbt_break_unit_bench.sv
`timescale 1ns/1ps
`include "hbt_consts.svh"

// ==========================================================================
// self-checking bench for the break unit
module hbt_break_unit_bench import hbt_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000, pcReq = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] evtReq = 16'h0000;
  logic [7:0] excReq = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, busCycle, breakReq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, pcAddr, q;
  logic [15:0] evtHit;
  logic [7:0] excEvt;
  int err_count = 0;
  int samples_checked = 0;

  hbt_break_unit dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busCycle, .evtHit,
    .pcAddr, .excEvt, .breakReq);
  hbt_bus_model model (.clk, .nrst, .slow, .evtReq, .excReq, .pcReq,
    .busCycle, .evtHit, .excEvt, .pcAddr);

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one bus transfer; ready and answers judged at the falling edge
  task automatic xfer(input logic rd, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    logic ta, tw, tb, tar, tr;
    n = 0;
    if (rd) begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end else begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    do begin
      @(negedge clk);
      n++;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bready && s_axi_bvalid;
      tar = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rready && s_axi_rvalid;
      if (tb) rsp = s_axi_bresp;
      if (tr) q = s_axi_rdata;
      if (tr) rsp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      if (tar) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end while ((s_axi_bready || s_axi_rready) && n < 50);
    if (n >= 50) err_count++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b1, a, 32'h00000000);
  endtask

  task automatic apply;
    wr(`HBT_OFF_CMD, 32'h00000001);
  endtask

  // present events on one bus cycle, then let the result settle
  task automatic ev(input logic [15:0] e, input logic [7:0] x);
    evtReq <= e;
    excReq <= x;
    repeat (slow ? 2 : 1) @(posedge clk);
    evtReq <= 16'h0000;
    excReq <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  // judge the stop request; an expected stop is cleared again
  task automatic brk(input logic b);
    @(negedge clk);
    chk(32'(breakReq), 32'(b));
    @(posedge clk);
    if (b) wr(`HBT_OFF_CMD, 32'h00000002);
  endtask

  task automatic mode(input hbt_mode_t m, input logic [31:0] mask);
    wr(`HBT_OFF_CTRL, 32'h3 | (32'(m) << `HBT_CTRL_MODE));
    wr(`HBT_OFF_OTHMASK, mask);
    apply;
  endtask

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  task automatic s_defaults;
    rd(`HBT_OFF_CTRL);
    chk(q, `HBT_CTRL_RST);
    rd(`HBT_OFF_DELAY);
    chk(q, 32'h00000000);
    rd(8'hfc);
    chk(32'(rsp), 32'(`HBT_RESP_SLVERR));
    wr(8'hfc, 32'h00000001);
    chk(32'(rsp), 32'(`HBT_RESP_SLVERR));
  endtask

  task automatic s_or;
    wr(`HBT_OFF_ORMASK, 32'h00000008);
    ev(16'h0008, 8'h00);
    brk(1'b0);
    apply;
    ev(16'h0010, 8'h00);
    brk(1'b0);
    ev(16'h0008, 8'h00);
    brk(1'b1);
  endtask

  task automatic s_exc;
    for (int i = 0; i < 8; i++) begin
      wr(`HBT_OFF_EXCMASK, 32'h00000001 << i);
      apply;
      ev(16'h0000, ~(8'h01 << i));
      brk(1'b0);
      ev(16'h0000, 8'h01 << i);
      brk(1'b1);
    end
  endtask

  task automatic s_and;
    mode(HBT_CUM, 32'h00000006);
    ev(16'h0002, 8'h00);
    brk(1'b0);
    ev(16'h0004, 8'h00);
    brk(1'b1);
    ev(16'h0008, 8'h00);
    brk(1'b1);
    mode(HBT_SIM, 32'h00000006);
    ev(16'h0002, 8'h00);
    ev(16'h0004, 8'h00);
    brk(1'b0);
    ev(16'h0006, 8'h00);
    brk(1'b1);
  endtask

  task automatic s_sub;
    wr(`HBT_OFF_RLO, 32'h00001000);
    wr(`HBT_OFF_RHI, 32'h000010ff);
    mode(HBT_SUB, 32'h00000002);
    pcReq <= 32'h00000fff;
    ev(16'h0002, 8'h00);
    brk(1'b0);
    pcReq <= 32'h00001100;
    ev(16'h0002, 8'h00);
    brk(1'b0);
    pcReq <= 32'h000010ff;
    ev(16'h0002, 8'h00);
    brk(1'b1);
  endtask

  task automatic s_seq;
    wr(`HBT_OFF_ORMASK, 32'h00000000);
    wr(`HBT_OFF_SEQEVT, 32'h00654321);
    wr(`HBT_OFF_SEQLEN, 32'h00000006);
    wr(`HBT_OFF_RSTPT, 32'h00000017);
    mode(HBT_SEQ, 32'h00000000);
    for (int k = 1; k < 6; k++) ev(16'h0001 << k, 8'h00);
    ev(16'h0080, 8'h00);
    ev(16'h0040, 8'h00);
    brk(1'b0);
    for (int k = 1; k < 7; k++) ev(16'h0001 << k, 8'h00);
    brk(1'b1);
  endtask

  task automatic s_trn;
    wr(`HBT_OFF_PATH0, 32'h00000124);
    wr(`HBT_OFF_PATH0 + 8'h04, 32'h0000014d);
    mode(HBT_TRN, 32'h00000000);
    ev(16'h0010, 8'h00);
    ev(16'h0004, 8'h00);
    brk(1'b0);
    ev(16'h0010, 8'h00);
    brk(1'b1);
  endtask

  task automatic s_limit;
    wr(`HBT_OFF_ORMASK, 32'h0000ffff);
    mode(HBT_CUM, 32'h00000001);
    rd(`HBT_OFF_STATUS);
    chk(q & 32'h00000004, 32'h00000004);
    ev(16'h0001, 8'h00);
    brk(1'b0);
    wr(`HBT_OFF_CTRL, 32'h00000002);
    wr(`HBT_OFF_CTRL, 32'h00000003);
    rd(`HBT_OFF_ORMASK);
    chk(q, 32'h00000000);
    wr(`HBT_OFF_ORMASK, 32'h00000003);
    wr(`HBT_OFF_CTRL, 32'h00000002);
    wr(`HBT_OFF_CTRL, 32'h00000003);
    rd(`HBT_OFF_ORMASK);
    chk(q, 32'h00000003);
  endtask

  // count bus cycles from the match to the stop on a slow bus
  task automatic s_delay;
    int n, cnt;
    logic seen;
    n = 0;
    cnt = 0;
    seen = 1'b0;
    wr(`HBT_OFF_ORMASK, 32'h00000008);
    wr(`HBT_OFF_DELAY, 32'h00000003);
    wr(`HBT_OFF_CTRL, 32'h00000101);
    apply;
    slow <= 1'b1;
    evtReq <= 16'h0008;
    while (n < 40) begin
      @(negedge clk);
      n++;
      if (breakReq) n = 40;
      else if (seen && busCycle) cnt++;
      if (busCycle && evtHit[3]) seen = 1'b1;
      @(posedge clk);
      if (n == 2) evtReq <= 16'h0000;
    end
    chk(32'(cnt), 32'h00000003);
    brk(1'b1);
    slow <= 1'b0;
  endtask

  initial begin
    do_reset;
    s_defaults;
    s_or;
    s_exc;
    s_and;
    s_sub;
    s_seq;
    s_trn;
    s_limit;
    s_delay;
    ev(16'h0008, 8'h00);
    do_reset;
    brk(1'b0);
    s_defaults;
    complete_run;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (10000) @(posedge clk);
    err_count++;
    complete_run;
  end
endmodule

bind hbt_break_unit hbt_break_unit_monitor mon (.clk, .nrst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .busCycle, .breakReq);
